//--- include/dtop_defs.svh
`ifndef DTOP_DEFS_SVH
`define DTOP_DEFS_SVH

// Register map, byte-wide registers on a 4-bit address
`define DTOP_ADDR_FIRST_TIMER_LOW_COUNT   4'h0
`define DTOP_ADDR_FIRST_TIMER_HIGH_COUNT  4'h1
`define DTOP_ADDR_SECOND_TIMER_LOW_COUNT  4'h2
`define DTOP_ADDR_SECOND_TIMER_HIGH_COUNT 4'h3
`define DTOP_ADDR_FIRST_TIMER_MODE_REG    4'h4
`define DTOP_ADDR_SECOND_TIMER_MODE_REG   4'h5
`define DTOP_ADDR_EDGE_POLARITY_SELECT    4'h6
`define DTOP_ADDR_SHARED_TIMER_RUN_CTRL   4'h7
`define DTOP_ADDR_IRQ_REQUEST_GROUP_ONE   4'h8
`define DTOP_ADDR_IRQ_REQUEST_GROUP_TWO   4'h9

// Mode register fields
`define DTOP_MODE_SEL_LSB   0
`define DTOP_MODE_SEL_MSB   2
`define DTOP_MODE_WR_LATCH  3
`define DTOP_MODE_SRC_LSB   5
`define DTOP_MODE_SRC_MSB   6

// Mode select codes
`define DTOP_MODE_PULSE_CYC 3'h2
`define DTOP_MODE_PULSE_WID 3'h3
`define DTOP_MODE_ONESHOT   3'h5
`define DTOP_MODE_PWM       3'h6

// Edge/polarity select: trigger edge bits from 0, pulse polarity bits from 2
`define DTOP_EDGE_TRIG_LSB  0
`define DTOP_EDGE_POL_LSB   2

// Count source select codes and divider masks
`define DTOP_SRC_DIV2       2'h0
`define DTOP_SRC_DIV8       2'h1
`define DTOP_DIV2_MASK      4'h1
`define DTOP_DIV8_MASK      4'h7
`define DTOP_DIV16_MASK     4'hF

// Reset values
`define DTOP_RST_MODE       8'h00
`define DTOP_RST_EDGE       8'h00
`define DTOP_RST_RUN        8'h03
`define DTOP_RST_COUNT      16'hFFFF

`endif

//--- include/dtop_pkg.sv
package dtop_pkg;

    localparam int DTOP_NUM_TIMERS = 2;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] latch;
        logic [7:0]  ph;
        logic        hi;
        logic        act;
        logic        pout;
        logic        trig_q;
        logic [2:0]  mode_q;
    } dtop_timer_s;

    typedef struct packed {
        dtop_timer_s [DTOP_NUM_TIMERS-1:0] tmr;
        logic [DTOP_NUM_TIMERS-1:0][7:0]   mode;
        logic [7:0]                        edge_sel;
        logic [7:0]                        run_ctl;
        logic [7:0]                        irq1;
        logic [7:0]                        irq2;
        logic [7:0]                        rdata;
    } dtop_state_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dtop_bus_s;

endpackage

//--- hw/dtop_prescaler.sv
`timescale 1ns/1ps
`include "dtop_defs.svh"

module dtop_prescaler
    import dtop_pkg::*;
#(
    parameter int N = DTOP_NUM_TIMERS
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_nrst,
    input  wire logic [N-1:0][1:0]   i_src_sel,
    output logic      [N-1:0]        o_tick
);

    // One shared divider keeps the two timers phase aligned
    logic [3:0] div_q;
    logic [3:0] div_d;

    always_comb begin
        div_d = div_q + 4'h1;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_tick
            always_comb begin
                case (i_src_sel[g])
                    `DTOP_SRC_DIV2: o_tick[g] = (div_q & `DTOP_DIV2_MASK) == `DTOP_DIV2_MASK;
                    `DTOP_SRC_DIV8: o_tick[g] = (div_q & `DTOP_DIV8_MASK) == `DTOP_DIV8_MASK;
                    default:        o_tick[g] = div_q == `DTOP_DIV16_MASK;
                endcase
            end
        end
    endgenerate

endmodule

//--- hw/dtop_timers.sv
`timescale 1ns/1ps
`include "dtop_defs.svh"

// Behaviour
// - Mode code 101 selects one-shot output
// - Count clock is input over 2, 8, 16
// - Trigger edge bit: 0 falling, 1 rising
// - Active trigger edge sets group-two request bit
// - Polarity 0: idle low, pulse high
// - Polarity 1: idle high, pulse low
// - Width from count bytes; stopped ignores triggers
// - Polarity change flips pulse level at once
// - Mode code 110 selects PWM on pin
// - High n periods, low m periods
// - PWM rising edge sets group-one request
// - Stopped PWM write loads both, forces high
// - Running PWM repeats high then low
// - Latch-only PWM counts apply after underflow
// - Zero high holds low, zero low high
// - Any zero PWM count raises no request
// - Latch-only value reaches counter at underflow
// - Live count readable except measurement modes
// - Edge bits also set pin interrupt polarity
// - Run bit 0 counts, 1 holds
module dtop_timers
    import dtop_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic [1:0]  i_trigger_pin,
    output logic      [1:0]  o_pulse_pin,
    output logic      [1:0]  o_irq_request_group_one,
    output logic      [1:0]  o_irq_request_group_two
);

    dtop_state_s             s_q;
    dtop_state_s             s_d;
    dtop_bus_s               bus;
    logic [DTOP_NUM_TIMERS-1:0]      tick;
    logic [DTOP_NUM_TIMERS-1:0][1:0] src_sel;

    assign bus.addr  = i_addr;
    assign bus.wdata = i_wdata;
    assign bus.wr    = i_wr;
    assign bus.rd    = i_rd;

    genvar g;
    generate
        for (g = 0; g < DTOP_NUM_TIMERS; g++) begin : g_src
            assign src_sel[g] = s_q.mode[g][`DTOP_MODE_SRC_MSB:`DTOP_MODE_SRC_LSB];
        end
    endgenerate

    dtop_prescaler #(
        .N (DTOP_NUM_TIMERS)
    ) u_prescaler (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_src_sel (src_sel),
        .o_tick    (tick)
    );

    always_comb begin
        logic [7:0]  set1;
        logic [7:0]  set2;
        logic [2:0]  code;
        logic        running;
        logic        entering;
        logic        trig_edge;
        logic        pol;
        logic        wr_lo;
        logic        wr_hi;
        logic        wr_both;
        logic [7:0]  n_cur;
        logic [7:0]  m_cur;
        logic [7:0]  n_new;
        logic [7:0]  m_new;
        logic [15:0] live;
        set1      = 8'h00;
        set2      = 8'h00;
        code      = 3'h0;
        running   = 1'b0;
        entering  = 1'b0;
        trig_edge = 1'b0;
        pol       = 1'b0;
        wr_lo     = 1'b0;
        wr_hi     = 1'b0;
        wr_both   = 1'b0;
        n_cur     = 8'h00;
        m_cur     = 8'h00;
        n_new     = 8'h00;
        m_new     = 8'h00;
        live      = 16'h0000;
        s_d       = s_q;

        for (int i = 0; i < DTOP_NUM_TIMERS; i++) begin
            code     = s_q.mode[i][`DTOP_MODE_SEL_MSB:`DTOP_MODE_SEL_LSB];
            running  = ~s_q.run_ctl[i];
            entering = code != s_q.tmr[i].mode_q;
            pol      = s_q.edge_sel[`DTOP_EDGE_POL_LSB + i];
            // Edge select doubles as the pin interrupt polarity
            if (s_q.edge_sel[`DTOP_EDGE_TRIG_LSB + i]) begin
                trig_edge = i_trigger_pin[i] & ~s_q.tmr[i].trig_q;
            end else begin
                trig_edge = ~i_trigger_pin[i] & s_q.tmr[i].trig_q;
            end
            if (trig_edge) begin
                set2[i] = 1'b1;
            end
            s_d.tmr[i].trig_q = i_trigger_pin[i];
            s_d.tmr[i].mode_q = code;
            n_cur = s_q.tmr[i].cnt[15:8];
            m_cur = s_q.tmr[i].cnt[7:0];
            n_new = s_q.tmr[i].latch[15:8];
            m_new = s_q.tmr[i].latch[7:0];

            case (code)
                `DTOP_MODE_ONESHOT: begin
                    if (entering) begin
                        s_d.tmr[i].act = 1'b0;
                    end else if (running && trig_edge && !s_q.tmr[i].act) begin
                        // Stopped timer lets the edge through only as a request
                        s_d.tmr[i].act = 1'b1;
                        s_d.tmr[i].cnt = s_q.tmr[i].latch;
                    end else if (running && s_q.tmr[i].act && tick[i]) begin
                        if (s_q.tmr[i].cnt == 16'h0000) begin
                            s_d.tmr[i].act = 1'b0;
                            s_d.tmr[i].cnt = s_q.tmr[i].latch;
                            set1[i]        = 1'b1;
                        end else begin
                            s_d.tmr[i].cnt = s_q.tmr[i].cnt - 16'h0001;
                        end
                    end
                    // Level follows polarity live, so a polarity write inverts it
                    s_d.tmr[i].pout = pol ^ s_d.tmr[i].act;
                end
                `DTOP_MODE_PWM: begin
                    if (entering) begin
                        s_d.tmr[i].pout = 1'b1;
                        s_d.tmr[i].hi   = 1'b1;
                        s_d.tmr[i].ph   = n_cur;
                    end else if (running && tick[i]) begin
                        if (n_cur == 8'h00 || m_cur == 8'h00) begin
                            // Degenerate counts: flat level, no request
                            s_d.tmr[i].pout = n_cur != 8'h00;
                            s_d.tmr[i].cnt  = s_q.tmr[i].latch;
                            s_d.tmr[i].hi   = 1'b1;
                            s_d.tmr[i].ph   = n_new;
                        end else if (s_q.tmr[i].ph > 8'h01) begin
                            s_d.tmr[i].ph = s_q.tmr[i].ph - 8'h01;
                        end else if (s_q.tmr[i].hi) begin
                            s_d.tmr[i].hi   = 1'b0;
                            s_d.tmr[i].ph   = m_cur;
                            s_d.tmr[i].pout = 1'b0;
                        end else begin
                            // Period end is the underflow: latch values take over
                            s_d.tmr[i].cnt  = s_q.tmr[i].latch;
                            s_d.tmr[i].hi   = 1'b1;
                            s_d.tmr[i].ph   = n_new;
                            s_d.tmr[i].pout = n_new != 8'h00;
                            if (n_new != 8'h00 && m_new != 8'h00) begin
                                set1[i] = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    if (running && tick[i]) begin
                        if (s_q.tmr[i].cnt == 16'h0000) begin
                            s_d.tmr[i].cnt = s_q.tmr[i].latch;
                            set1[i]        = 1'b1;
                        end else begin
                            s_d.tmr[i].cnt = s_q.tmr[i].cnt - 16'h0001;
                        end
                    end
                end
            endcase

            // Count byte writes; a write near an underflow simply wins
            wr_lo   = bus.wr && bus.addr == 4'(2 * i);
            wr_hi   = bus.wr && bus.addr == 4'(2 * i + 1);
            wr_both = !s_q.mode[i][`DTOP_MODE_WR_LATCH] ||
                      (code == `DTOP_MODE_PWM && !running);
            if (wr_lo) begin
                s_d.tmr[i].latch[7:0] = bus.wdata;
                if (wr_both) begin
                    s_d.tmr[i].cnt[7:0] = bus.wdata;
                end
            end
            if (wr_hi) begin
                s_d.tmr[i].latch[15:8] = bus.wdata;
                if (wr_both) begin
                    s_d.tmr[i].cnt[15:8] = bus.wdata;
                end
            end
            if ((wr_lo || wr_hi) && code == `DTOP_MODE_PWM && !running) begin
                s_d.tmr[i].pout = 1'b1;
                s_d.tmr[i].hi   = 1'b1;
                s_d.tmr[i].ph   = s_d.tmr[i].cnt[15:8];
            end
        end

        if (bus.wr) begin
            case (bus.addr)
                `DTOP_ADDR_FIRST_TIMER_MODE_REG:  s_d.mode[0]  = bus.wdata;
                `DTOP_ADDR_SECOND_TIMER_MODE_REG: s_d.mode[1]  = bus.wdata;
                `DTOP_ADDR_EDGE_POLARITY_SELECT:  s_d.edge_sel = bus.wdata & 8'h0F;
                `DTOP_ADDR_SHARED_TIMER_RUN_CTRL: s_d.run_ctl  = bus.wdata & 8'h03;
                // Writing 0 clears a request bit, writing 1 leaves it
                `DTOP_ADDR_IRQ_REQUEST_GROUP_ONE: s_d.irq1     = s_q.irq1 & bus.wdata;
                `DTOP_ADDR_IRQ_REQUEST_GROUP_TWO: s_d.irq2     = s_q.irq2 & bus.wdata;
                default: begin
                end
            endcase
        end
        // New events outrank a simultaneous clear
        s_d.irq1 = (s_d.irq1 | set1) & 8'h03;
        s_d.irq2 = (s_d.irq2 | set2) & 8'h03;

        s_d.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `DTOP_ADDR_FIRST_TIMER_LOW_COUNT,
                `DTOP_ADDR_FIRST_TIMER_HIGH_COUNT,
                `DTOP_ADDR_SECOND_TIMER_LOW_COUNT,
                `DTOP_ADDR_SECOND_TIMER_HIGH_COUNT: begin
                    // Latch is write-only; measurement modes hide the count
                    live = s_q.tmr[bus.addr[1]].cnt;
                    code = s_q.mode[bus.addr[1]][`DTOP_MODE_SEL_MSB:`DTOP_MODE_SEL_LSB];
                    if (code != `DTOP_MODE_PULSE_CYC && code != `DTOP_MODE_PULSE_WID) begin
                        s_d.rdata = bus.addr[0] ? live[15:8] : live[7:0];
                    end
                end
                `DTOP_ADDR_FIRST_TIMER_MODE_REG:  s_d.rdata = s_q.mode[0];
                `DTOP_ADDR_SECOND_TIMER_MODE_REG: s_d.rdata = s_q.mode[1];
                `DTOP_ADDR_EDGE_POLARITY_SELECT:  s_d.rdata = s_q.edge_sel;
                `DTOP_ADDR_SHARED_TIMER_RUN_CTRL: s_d.rdata = s_q.run_ctl;
                `DTOP_ADDR_IRQ_REQUEST_GROUP_ONE: s_d.rdata = s_q.irq1;
                `DTOP_ADDR_IRQ_REQUEST_GROUP_TWO: s_d.rdata = s_q.irq2;
                default:                          s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < DTOP_NUM_TIMERS; i++) begin
                s_q.tmr[i].cnt    <= `DTOP_RST_COUNT;
                s_q.tmr[i].latch  <= `DTOP_RST_COUNT;
                s_q.tmr[i].ph     <= 8'h00;
                s_q.tmr[i].hi     <= 1'b0;
                s_q.tmr[i].act    <= 1'b0;
                s_q.tmr[i].pout   <= 1'b0;
                s_q.tmr[i].trig_q <= 1'b0;
                s_q.tmr[i].mode_q <= 3'h0;
                s_q.mode[i]       <= `DTOP_RST_MODE;
            end
            s_q.edge_sel <= `DTOP_RST_EDGE;
            s_q.run_ctl  <= `DTOP_RST_RUN;
            s_q.irq1     <= 8'h00;
            s_q.irq2     <= 8'h00;
            s_q.rdata    <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata                 = s_q.rdata;
    assign o_pulse_pin             = {s_q.tmr[1].pout, s_q.tmr[0].pout};
    assign o_irq_request_group_one = s_q.irq1[1:0];
    assign o_irq_request_group_two = s_q.irq2[1:0];

endmodule

//--- verif/dtop_timers_properties.sv
`timescale 1ns/1ps
module dtop_timers_properties (
    input wire logic       i_sys_clk,
    input wire logic       i_nrst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [1:0] i_trigger_pin,
    input wire logic [1:0] o_pulse_pin,
    input wire logic [1:0] o_irq_request_group_one,
    input wire logic [1:0] o_irq_request_group_two
);
    // Timer 0 control rebuilt from the bus, so the checker needs no internals
    logic [2:0] mode_q;
    logic [7:0] eg_q;
    logic       stop_q;
    logic [7:0] hi_q;
    logic [7:0] lo_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_q <= 3'h0;
            eg_q   <= 8'h00;
            stop_q <= 1'b1;
            hi_q   <= 8'hFF;
            lo_q   <= 8'hFF;
        end else if (i_wr) begin
            if (i_addr == 4'h4) mode_q <= i_wdata[2:0];
            if (i_addr == 4'h6) eg_q <= i_wdata;
            if (i_addr == 4'h7) stop_q <= i_wdata[0];
            if (i_addr == 4'h1) hi_q <= i_wdata;
            if (i_addr == 4'h0) lo_q <= i_wdata;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_enter(logic [2:0] code);
        i_wr && i_addr == 4'h4 && i_wdata[2:0] == code && mode_q != code;
    endsequence
    sequence s_os_idle;
        mode_q == 3'h5 && stop_q && !(i_wr && i_addr == 4'h6);
    endsequence
    sequence s_pwm_zero;
        mode_q == 3'h6 && !stop_q && (hi_q == 8'h00 || lo_q == 8'h00);
    endsequence

    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_trig_sets_req: assert property ((eg_q[0] ? $rose(i_trigger_pin[0]) : $fell(i_trigger_pin[0])) |-> ##[1:3] o_irq_request_group_two[0])
        else $error("trigger edge left no request");
    a_oneshot_entry: assert property (s_enter(3'h5) |-> ##2 o_pulse_pin[0] == eg_q[2])
        else $error("one-shot entry level wrong");
    a_pwm_entry: assert property (s_enter(3'h6) ##0 stop_q |-> ##3 o_pulse_pin[0])
        else $error("pwm entry not high");
    a_pol_flip: assert property (i_wr && i_addr == 4'h6 && mode_q == 3'h5 && i_wdata[2] != eg_q[2] |-> ##2 $changed(o_pulse_pin[0]))
        else $error("polarity change did not flip pin");
    a_stopped_idle: assert property (s_os_idle [*3] |-> o_pulse_pin[0] == eg_q[2])
        else $error("stopped one-shot left idle level");
    a_pwm_rise_req: assert property ($rose(o_pulse_pin[0]) && mode_q == 3'h6 && !stop_q && hi_q != 8'h00 && lo_q != 8'h00 |-> ##[1:3] o_irq_request_group_one[0])
        else $error("pwm rise without request");
    a_pwm_zero_quiet: assert property (s_pwm_zero [*3] |-> !$rose(o_irq_request_group_one[0]))
        else $error("request with zero pwm count");
endmodule

bind dtop_timers dtop_timers_properties dtop_timers_properties_i (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_trigger_pin(i_trigger_pin), .o_pulse_pin(o_pulse_pin),
    .o_irq_request_group_one(o_irq_request_group_one),
    .o_irq_request_group_two(o_irq_request_group_two));

//--- verif/dtop_partner.sv
`timescale 1ns/1ps
module dtop_partner (
    input  wire logic       i_sys_clk,
    input  wire logic [1:0] i_level,
    input  wire logic [1:0] i_pulse_pin,
    output logic      [1:0] o_trigger_pin,
    output int              o_high_len,
    output int              o_low_len
);
    logic last = 1'b0;
    int   run  = 0;

    initial o_trigger_pin = 2'b00;
    initial o_high_len = 0;
    initial o_low_len = 0;
    // Bench holds each level at least 300 ns, just beyond the 250 ns minimum width
    always @(posedge i_sys_clk) begin
        o_trigger_pin <= i_level;
        last <= i_pulse_pin[0];
        run <= (i_pulse_pin[0] !== last) ? 1 : run + 1;
        if (i_pulse_pin[0] !== last && last) o_high_len <= run;
        if (i_pulse_pin[0] !== last && !last) o_low_len <= run;
    end
endmodule

//--- verif/dtop_timers_tb_top.sv
`timescale 1ns/1ps
module dtop_timers_tb_top;
    logic       i_sys_clk = 1'b0;
    logic       i_nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [1:0] lvl = 2'b00;
    logic [7:0] rdata, rv, n, m;
    logic [1:0] trig, pulse, irq1, irq2;
    logic       pol, edg;
    int         hi_len, lo_len, w, k, fails = 0, tests_run = 0, cycles = 0;
    integer     seed = 32'h7dd09d46;

    always #5 i_sys_clk = ~i_sys_clk;

    dtop_timers dtop_timers_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_trigger_pin(trig),
        .o_pulse_pin(pulse), .o_irq_request_group_one(irq1), .o_irq_request_group_two(irq2));
    dtop_partner dtop_partner_i (.i_sys_clk(i_sys_clk), .i_level(lvl), .i_pulse_pin(pulse),
        .o_trigger_pin(trig), .o_high_len(hi_len), .o_low_len(lo_len));

    task automatic wrap_up();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_len(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED t=%0t length %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge i_sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_sys_clk);
        rd <= 1'b0;
        @(negedge i_sys_clk);
        rv = rdata;
    endtask

    task automatic gap(input int c);
        repeat (c) @(negedge i_sys_clk);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    function automatic logic [7:0] rst_val(input logic [3:0] a);
        return (a < 4'h4) ? 8'hFF : (a == 4'h7) ? 8'h03 : 8'h00;
    endfunction

    function automatic logic [7:0] rnd();
        return 8'(($random(seed) & 7) + 1);
    endfunction

    function automatic int div(input int s);
        return (s == 0) ? 2 : (s == 1) ? 8 : 16;
    endfunction

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        for (k = 0; k < 16; k++) begin
            rd_reg(k[3:0]);
            chk(rv, rst_val(k[3:0]));
        end
        n = rnd();
        wr_reg(4'h0, n);
        rd_reg(4'h0);
        chk(rv, n);
        wr_reg(4'h4, 8'h08);
        wr_reg(4'h0, ~n);
        rd_reg(4'h0);
        chk(rv, n);
        done("registers");
        for (k = 0; k < 4; k++) begin
            pol = k[1];
            edg = k[0];
            wr_reg(4'h7, 8'h03);
            @(posedge i_sys_clk) lvl <= {1'b0, ~edg};
            gap(30);
            wr_reg(4'h6, {5'h00, pol, 1'b0, edg});
            wr_reg(4'h4, 8'h00);
            wr_reg(4'h4, 8'h05);
            wr_reg(4'h0, 8'h03);
            wr_reg(4'h1, 8'h00);
            wr_reg(4'h9, 8'h00);
            @(posedge i_sys_clk) lvl <= {1'b0, edg};
            gap(30);
            chk({6'h00, pulse}, {7'h00, pol});
            rd_reg(4'h9);
            chk(rv, 8'h01);
            wr_reg(4'h8, 8'h00);
            @(posedge i_sys_clk) lvl <= {1'b0, ~edg};
            gap(30);
            wr_reg(4'h7, 8'h02);
            @(posedge i_sys_clk) lvl <= {1'b0, edg};
            gap(5);
            chk({6'h00, pulse}, {7'h00, ~pol});
            gap(30);
            chk({6'h00, pulse}, {7'h00, pol});
            w = pol ? lo_len : hi_len;
            chk_len(w, (w == 8) ? 8 : 7);
            rd_reg(4'h8);
            chk(rv, 8'h01);
            wr_reg(4'h6, {5'h00, ~pol, 1'b0, edg});
            gap(4);
            chk({6'h00, pulse}, {7'h00, ~pol});
            done("one-shot");
        end
        for (k = 0; k < 3; k++) begin
            n = rnd();
            m = rnd();
            wr_reg(4'h7, 8'h03);
            wr_reg(4'h4, 8'h00);
            wr_reg(4'h4, {1'b0, k[1:0], 5'h06});
            wr_reg(4'h1, n);
            wr_reg(4'h0, m);
            wr_reg(4'h8, 8'h00);
            gap(3);
            chk({6'h00, pulse}, 8'h01);
            wr_reg(4'h7, 8'h02);
            gap(3 * (n + m) * div(k) + 20);
            chk_len(hi_len, n * div(k));
            chk_len(lo_len, m * div(k));
            rd_reg(4'h8);
            chk(rv, 8'h01);
            done("pwm");
        end
        for (k = 0; k < 3; k++) begin
            wr_reg(4'h7, 8'h03);
            wr_reg(4'h1, (k == 1) ? 8'h04 : 8'h00);
            wr_reg(4'h0, (k == 0) ? 8'h04 : 8'h00);
            wr_reg(4'h8, 8'h00);
            wr_reg(4'h7, 8'h02);
            gap(200);
            chk({6'h00, pulse}, {7'h00, k == 1});
            rd_reg(4'h8);
            chk(rv, 8'h00);
        end
        done("pwm zero");
        wr_reg(4'h7, 8'h03);
        wr_reg(4'h4, 8'h0E);
        wr_reg(4'h1, 8'h04);
        wr_reg(4'h0, 8'h04);
        wr_reg(4'h7, 8'h02);
        gap(50);
        chk_len(hi_len, 8);
        wr_reg(4'h1, 8'h02);
        gap(60);
        chk_len(hi_len, 4);
        done("pwm latch");
        // Second trigger pin and count read hiding on the second timer
        wr_reg(4'h9, 8'h00);
        @(posedge i_sys_clk) lvl <= {1'b1, lvl[0]};
        gap(30);
        @(posedge i_sys_clk) lvl <= {1'b0, lvl[0]};
        gap(30);
        rd_reg(4'h9);
        chk(rv, 8'h02);
        wr_reg(4'h5, 8'h02);
        rd_reg(4'h3);
        chk(rv, 8'h00);
        wr_reg(4'h5, 8'h00);
        rd_reg(4'h3);
        chk(rv, 8'hFF);
        done("second timer");
        wrap_up();
    end
endmodule
